/* File: hdl/divide_sequencer.sv */
`timescale 1ns/1ps
// How it works
// - divides 72-bit sum register by 36-bit divisor; quotient to ratio register.
// - prolong sets extend flag; phases: correction, shift, division, end correction.
// - two overflow checks in division; failure raises quotient-overflow halt.
// - quotient times divisor equals dividend minus positive, smaller remainder.
// - add records 0, subtract 1; final quotient rotates left with top bit.
// - divisor stays put; dividend prealigned then shifted left each step.
// - negative dividend, positive divisor: set flags, subtract divisor full width.
// - negative dividend, negative divisor: set flags, add sign-extended divisor full width.
// - corrections probe in fixed order; final probe sets prealign-active.
// - positive dividend clears sign flag, sets started and prealign directly.
// - each prealign pulse shifts sum left, decrements tally, tests for one.
// - 36th pulse raises shift-done, clears prealign, sets quotient flags, reloads 36.
// - after prealign the dividend top bit sits at bit 35.
// - quotient phase runs 36 steps: shift, compare, add/sub, record, shift ratio.
// - step with tally one sets end-probe, clears extend, applies end correction, ends.
module divide_sequencer #(
  parameter int unsigned ACC_W  = divide_pkg::ACC_W,
  parameter int unsigned WORD_W = divide_pkg::WORD_W
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              load_tally,      // set shift tally to 36
  input  wire logic              begin_divide,
  input  wire logic              prolong_seq,
  input  wire logic [ACC_W-1:0]  dividend_in,
  input  wire logic [WORD_W-1:0] divisor_in,
  input  wire logic              load_operands,
  output logic [ACC_W-1:0]       sum_reg,
  output logic [WORD_W-1:0]      ratio_reg,
  output logic [WORD_W-1:0]      divisor_reg,
  output logic [6:0]             shift_tally,
  output logic                   extend_seq,
  output logic                   divide_started,
  output logic                   dividend_sign,
  output logic                   deferred_sum,
  output logic                   prealign_active,
  output logic                   quotient_phase,
  output logic                   quotient_step,
  output logic                   end_probe,
  output logic                   shift_done,
  output logic                   overflow_halt,
  output logic                   divide_done
);

  // ***************************************************************
  // datapath helpers
  // ***************************************************************
  divide_pkg::seq_state_e state_q;
  logic [ACC_W-1:0]  sum_q;
  logic [WORD_W-1:0] ratio_q;
  logic [WORD_W-1:0] div_q;
  logic [6:0]        tally_q;
  logic [ACC_W-1:0]  operand;
  logic [ACC_W-1:0]  added;
  logic [ACC_W-1:0]  shifted;
  logic              do_sub;
  logic              step_cnt_q;    // only ever cleared; checks_q tracks the first two steps
  logic [1:0]        checks_q;
  logic [ACC_W-1:0]  x_ext;
  logic              end_neg_q;     // remainder sign before the end correction

  // sign-extended divisor, aligned under the low half of the sum register
  assign x_ext   = {{(ACC_W-WORD_W){div_q[divide_pkg::WORD_SIGN]}}, div_q};
  assign shifted = {sum_q[ACC_W-2:0], sum_q[ACC_W-1]};
  // sign read before the shift: doubling can spill past bit 35 with a large divisor
  assign do_sub  = (sum_q[divide_pkg::WORD_SIGN] == div_q[divide_pkg::WORD_SIGN]);
  // subtraction is addition of the complement, as the hardware does
  assign operand = (state_q == divide_pkg::ST_STEP) ? (do_sub ? ~x_ext : x_ext)
                 : (state_q == divide_pkg::ST_CORRECT)
                   ? (div_q[divide_pkg::WORD_SIGN] ? x_ext : ~x_ext)
                 : (div_q[divide_pkg::WORD_SIGN] ? ~x_ext : x_ext);

  oc_add #(.W(ACC_W)) u_add (
    .a   (state_q == divide_pkg::ST_STEP ? shifted : sum_q),
    .b   (operand),
    .sum (added)
  );

  // ***************************************************************
  // sequencer
  // ***************************************************************
  // one state per phase; begin and prolong arrive together, tally preloaded
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q    <= divide_pkg::ST_IDLE;
      step_cnt_q <= 1'b0;
      checks_q   <= 2'h0;
    end else begin
      case (state_q)
        divide_pkg::ST_IDLE: begin
          if (begin_divide) begin
            checks_q   <= 2'h0;
            step_cnt_q <= 1'b0;
            state_q    <= dividend_in_sign() ? divide_pkg::ST_CORRECT
                                             : divide_pkg::ST_ALIGN;
          end
        end
        divide_pkg::ST_CORRECT: state_q <= divide_pkg::ST_ALIGN;
        divide_pkg::ST_ALIGN: begin
          if (tally_q == divide_pkg::TALLY_ONE) begin
            state_q <= divide_pkg::ST_STEP;
          end
        end
        divide_pkg::ST_STEP: begin
          // first check after step one, second after step two
          if (checks_q == 2'h0 && added[divide_pkg::WORD_SIGN] != added[divide_pkg::ALIGN_BIT])
            state_q <= divide_pkg::ST_HALT;
          else if (checks_q == 2'h1 && ratio_q[0] == do_sub)         // first two bits agree
            state_q <= divide_pkg::ST_HALT;
          else if (tally_q == divide_pkg::TALLY_ONE)
            state_q <= divide_pkg::ST_ENDCORR;
          if (checks_q != 2'h2) checks_q <= checks_q + 2'h1;
        end
        divide_pkg::ST_ENDCORR: state_q <= divide_pkg::ST_FIXQ;
        divide_pkg::ST_FIXQ:    state_q <= divide_pkg::ST_IDLE;
        divide_pkg::ST_HALT:    state_q <= divide_pkg::ST_IDLE;
        default:                state_q <= divide_pkg::ST_IDLE;
      endcase
    end
  end

  function automatic logic dividend_in_sign();
    dividend_in_sign = sum_q[divide_pkg::ACC_SIGN];
  endfunction : dividend_in_sign

  // ***************************************************************
  // operand registers
  // ***************************************************************
  // divisor never moves; sum shifts during prealign and each step
  always_ff @(posedge clock) begin
    if (reset) begin
      sum_q     <= '0;
      div_q     <= '0;
      ratio_q   <= '0;
      end_neg_q <= 1'b0;
    end else if (state_q == divide_pkg::ST_IDLE && load_operands) begin
      sum_q   <= dividend_in;
      div_q   <= divisor_in;
      ratio_q <= '0;
    end else begin
      case (state_q)
        divide_pkg::ST_CORRECT: sum_q <= added;
        divide_pkg::ST_ALIGN:   sum_q <= shifted;
        divide_pkg::ST_STEP: begin
          sum_q   <= added;
          ratio_q <= {ratio_q[WORD_W-2:0], do_sub};
        end
        divide_pkg::ST_ENDCORR: begin
          // negative remainder is pulled back positive
          if (sum_q[divide_pkg::ALIGN_BIT]) sum_q <= added;
          end_neg_q <= sum_q[divide_pkg::ALIGN_BIT];
          ratio_q <= {ratio_q[WORD_W-2:0], ratio_q[WORD_W-1]};
        end
        divide_pkg::ST_FIXQ: begin
          // quotient fix keys on the remainder sign seen before the end correction
          if (end_neg_q != dividend_sign)
            ratio_q[0] <= ratio_q[WORD_W-1];
        end
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // shift tally
  // ***************************************************************
  always_ff @(posedge clock) begin
    if (reset) tally_q <= divide_pkg::TALLY_ZERO;
    else if (load_tally) tally_q <= divide_pkg::TALLY_INIT;
    else if (state_q == divide_pkg::ST_ALIGN && tally_q == divide_pkg::TALLY_ONE)
      tally_q <= divide_pkg::TALLY_INIT;
    else if ((state_q == divide_pkg::ST_ALIGN || state_q == divide_pkg::ST_STEP)
             && tally_q != divide_pkg::TALLY_ZERO)
      tally_q <= tally_q - divide_pkg::TALLY_ONE;
  end

  // ***************************************************************
  // flags and outputs
  // ***************************************************************
  // flag set mirrors the sequencer flip-flops of the control section
  always_ff @(posedge clock) begin
    if (reset) begin
      extend_seq <= 1'b0; divide_started <= 1'b0; dividend_sign <= 1'b0;
      deferred_sum <= 1'b0; prealign_active <= 1'b0; quotient_phase <= 1'b0;
      quotient_step <= 1'b0; end_probe <= 1'b0; shift_done <= 1'b0;
      overflow_halt <= 1'b0; divide_done <= 1'b0;
    end else begin
      shift_done    <= 1'b0;
      overflow_halt <= 1'b0;
      divide_done   <= 1'b0;
      end_probe     <= 1'b0;
      if (state_q == divide_pkg::ST_IDLE && begin_divide) begin
        divide_started  <= 1'b1;
        dividend_sign   <= sum_q[divide_pkg::ACC_SIGN];
        deferred_sum    <= sum_q[divide_pkg::ACC_SIGN];
        prealign_active <= !sum_q[divide_pkg::ACC_SIGN];
      end
      if (state_q == divide_pkg::ST_CORRECT) begin
        deferred_sum    <= 1'b0;
        prealign_active <= 1'b1;
      end
      if (state_q == divide_pkg::ST_ALIGN && tally_q == divide_pkg::TALLY_ONE) begin
        shift_done      <= 1'b1;
        prealign_active <= 1'b0;
        quotient_phase  <= 1'b1;
        quotient_step   <= 1'b1;
      end
      if (state_q == divide_pkg::ST_STEP && tally_q == divide_pkg::TALLY_ONE) begin
        end_probe  <= 1'b1;
        extend_seq <= 1'b0;
      end
      if (state_q == divide_pkg::ST_STEP && checks_q != 2'h2 &&
          ((checks_q == 2'h0 && added[divide_pkg::WORD_SIGN] != added[divide_pkg::ALIGN_BIT])
           || (checks_q == 2'h1 && ratio_q[0] == do_sub))) begin
        overflow_halt <= 1'b1;
      end
      if (state_q == divide_pkg::ST_FIXQ || state_q == divide_pkg::ST_HALT) begin
        divide_done    <= (state_q == divide_pkg::ST_FIXQ);
        extend_seq     <= 1'b0;
        divide_started <= 1'b0;
        quotient_phase <= 1'b0;
        quotient_step  <= 1'b0;
      end
      // a new prolong wins over a clear in the same cycle
      if (prolong_seq) extend_seq <= 1'b1;
    end
  end

  // outputs straight from flops
  always_ff @(posedge clock) begin
    if (reset) begin
      sum_reg <= '0; ratio_reg <= '0; divisor_reg <= '0; shift_tally <= 7'h00;
    end else begin
      sum_reg     <= sum_q;
      ratio_reg   <= ratio_q;
      divisor_reg <= div_q;
      shift_tally <= tally_q;
    end
  end

endmodule : divide_sequencer

/* File: include/divide_pkg.sv */
package divide_pkg;

  // ***************************************************************
  // widths and counts
  // ***************************************************************
  localparam int unsigned ACC_W     = 72;
  localparam int unsigned WORD_W    = 36;
  localparam int unsigned TALLY_W   = 7;
  localparam logic [6:0]  TALLY_INIT = 7'h24;   // 36 steps / shifts
  localparam logic [6:0]  TALLY_ONE  = 7'h01;
  localparam logic [6:0]  TALLY_ZERO = 7'h00;
  localparam int unsigned ACC_SIGN  = 71;
  localparam int unsigned WORD_SIGN = 35;
  localparam int unsigned ALIGN_BIT = 36;

  // ***************************************************************
  // sequencer states
  // ***************************************************************
  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_CORRECT = 8'h02,
    ST_ALIGN   = 8'h04,
    ST_STEP    = 8'h08,
    ST_CHECK   = 8'h10,
    ST_ENDCORR = 8'h20,
    ST_FIXQ    = 8'h40,
    ST_HALT    = 8'h80
  } seq_state_e;

endpackage : divide_pkg

/* File: hdl/oc_add.sv */
`timescale 1ns/1ps
// ones'-complement adder with end-around carry
module oc_add #(
  parameter int unsigned W = 72
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  output logic      [W-1:0] sum
);
  logic [W:0] raw;

  // carry out of the top wraps into bit zero
  assign raw = {1'b0, a} + {1'b0, b};
  assign sum = raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};
endmodule : oc_add

/* File: dv/divide_monitor.sv */
`timescale 1ns/1ps
module divide_monitor #(
  parameter int unsigned ACC_W = divide_pkg::ACC_W
) (
  input wire logic             clock,
  input wire logic             reset,
  input wire logic             begin_divide,
  input wire logic             prolong_seq,
  input wire logic [ACC_W-1:0] dividend_in,
  input wire logic             extend_seq,
  input wire logic             divide_started,
  input wire logic             dividend_sign,
  input wire logic             deferred_sum,
  input wire logic             prealign_active,
  input wire logic             quotient_phase,
  input wire logic             quotient_step,
  input wire logic             shift_done,
  input wire logic             end_probe,
  input wire logic             overflow_halt
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // the alignment and quotient phases each take one tally of 36 pulses
  sequence align_run_s; ##[34:38] shift_done; endsequence
  sequence quot_run_s; ##[33:35] end_probe; endsequence
  a_prolong_sets_extend: assert property (prolong_seq |-> ##[1:3] extend_seq)
    else $error("extend flag missing after prolong");
  a_begin_sets_started: assert property (begin_divide |-> ##[1:3] divide_started)
    else $error("started flag missing after begin");
  a_pos_no_correct: assert property (begin_divide && !dividend_in[ACC_W-1] |->
    ##[1:3] (prealign_active && !dividend_sign && !deferred_sum))
    else $error("positive dividend not sent straight to alignment");
  a_neg_correct: assert property (begin_divide && dividend_in[ACC_W-1] |->
    ##[1:3] (dividend_sign && deferred_sum))
    else $error("negative dividend skipped the correction");
  a_align_length: assert property ($rose(prealign_active) |-> align_run_s)
    else $error("alignment did not end after 36 pulses");
  a_done_flags: assert property (shift_done |-> ##[0:2]
    (quotient_phase && quotient_step && !prealign_active))
    else $error("quotient flags wrong after alignment");
  a_quot_length: assert property (shift_done ##1 !overflow_halt ##1 !overflow_halt
    |-> quot_run_s)
    else $error("quotient phase length wrong");
  a_halt_early: assert property (overflow_halt |->
    ($past(shift_done, 1) || $past(shift_done, 2)))
    else $error("overflow halt outside the first two steps");
  a_end_clears_ext: assert property (end_probe |-> ##[0:2] !extend_seq)
    else $error("extend flag left set after end probe");
endmodule : divide_monitor
bind divide_sequencer divide_monitor #(.ACC_W(ACC_W)) u_mon (.clock, .reset, .begin_divide,
  .prolong_seq, .dividend_in, .extend_seq, .divide_started, .dividend_sign, .deferred_sum,
  .prealign_active, .quotient_phase, .quotient_step, .shift_done, .end_probe, .overflow_halt);

/* File: dv/command_timing_model.sv */
`timescale 1ns/1ps
module command_timing_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic go,
  input wire logic overflow_halt,
  output logic     load_tally,
  output logic     begin_divide,
  output logic     prolong_seq,
  output logic     halted
);
  logic go_q;
  initial {go_q, load_tally, begin_divide, prolong_seq, halted} = 5'h00;
  // tally loaded first, begin and prolong together one cycle later
  always @(negedge clock) begin
    load_tally <= go && !reset;
    go_q <= go && !reset;
    begin_divide <= go_q;
    prolong_seq <= go_q;
  end
  // a quotient overflow stops the machine until the next request
  always @(posedge clock) begin
    if (reset || go) halted <= 1'b0;
    else if (overflow_halt) halted <= 1'b1;
  end
endmodule : command_timing_model

/* File: dv/tb_divide_sequencer.sv */
`timescale 1ns/1ps
module tb_divide_sequencer;
  logic        clock, reset, go, load_operands, load_tally, begin_divide, prolong_seq;
  logic        halted, divide_done, overflow_halt;
  logic [71:0] dividend_in, sum_reg;
  logic [35:0] divisor_in, ratio_reg, divisor_reg;
  logic [6:0]  shift_tally;
  int          error_cnt, check_count, cycle_cnt;

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  divide_sequencer uut (.clock, .reset, .load_tally, .begin_divide, .prolong_seq,
    .dividend_in, .divisor_in, .load_operands, .sum_reg, .ratio_reg, .divisor_reg,
    .shift_tally, .extend_seq(), .divide_started(), .dividend_sign(), .deferred_sum(),
    .prealign_active(), .quotient_phase(), .quotient_step(), .end_probe(), .shift_done(),
    .overflow_halt, .divide_done);
  command_timing_model ctu (.clock, .reset, .go, .overflow_halt, .load_tally,
    .begin_divide, .prolong_seq, .halted);

  task check_val(input string what, input logic [71:0] exp, input logic [71:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task results;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  // operands first, then the command unit start, then wait for an outcome
  task run_div(input string name, input logic [71:0] dvd, input logic [35:0] dvs,
               input logic [35:0] q, input logic [35:0] r, input logic ovf);
    logic seen_done, seen_ovf;
    seen_done = 1'b0;
    seen_ovf = 1'b0;
    @(negedge clock);
    dividend_in <= dvd;
    divisor_in <= dvs;
    load_operands <= 1'b1;
    @(negedge clock);
    load_operands <= 1'b0;
    go <= 1'b1;
    @(negedge clock);
    go <= 1'b0;
    for (int i = 0; i < 200 && !seen_done && !seen_ovf; i++) begin
      @(posedge clock);
      #1;
      seen_done = (divide_done === 1'b1);
      seen_ovf = (overflow_halt === 1'b1);
    end
    // registered copies and the stop latch trail the pulse by one edge
    @(posedge clock);
    #1;
    check_val({name, " done"}, 72'(!ovf), 72'(seen_done));
    check_val({name, " divisor"}, 72'(dvs), 72'(divisor_reg));
    check_val({name, " halt"}, 72'(ovf), 72'(seen_ovf));
    check_val({name, " stop"}, 72'(ovf), 72'(halted));
    if (!ovf) begin
      check_val({name, " quotient"}, 72'(q), 72'(ratio_reg));
      check_val({name, " remainder"}, 72'(r), 72'(sum_reg[35:0]));
      check_val({name, " tally"}, 72'(divide_pkg::TALLY_ZERO), 72'(shift_tally));
    end
    repeat (3) @(negedge clock);
    $display("test %s finished", name);
  endtask : run_div

  // hang guard, well above five divides of about 80 cycles each
  always @(posedge clock) begin
    cycle_cnt++;
    if (cycle_cnt == 3000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    {reset, go, load_operands} = 3'h4;
    dividend_in = 72'h00;
    divisor_in = 36'h0;
    repeat (2) @(negedge clock);
    reset <= 1'b0;
    run_div("pos_pos", 72'h1E, 36'h7, 36'h4, 36'h2, 1'b0);
    run_div("neg_pos", 72'hFF_FFFF_FFFF_FFFF_FFE1, 36'h7, 36'hF_FFFF_FFFA, 36'h5, 1'b0);
    run_div("neg_neg", 72'hFF_FFFF_FFFF_FFFF_FFE1, 36'hF_FFFF_FFF8, 36'h5, 36'h5, 1'b0);
    run_div("pos_neg", 72'h1E, 36'hF_FFFF_FFF8, 36'hF_FFFF_FFFB, 36'h2, 1'b0);
    run_div("too_big", 72'h70_0000_0000, 36'h7, 36'h0, 36'h0, 1'b1);
    results();
  end
endmodule : tb_divide_sequencer
